// ==== usrx_regs.vh ====
// Constants for the SPI slave receive path with test-mode pin routing
// Contract
// - Completed character loads holding reg, sets ready, except in remote loopback mode
// - Completion while ready set raises overrun, unless a read comes in the same cycle
// - Newest character overwrites holding reg in all modes but remote loopback
// - Overrun clears only on status-clear command
// - Receiver starts on select low level
// - Transmitter starts on select low level
// - Receiver timeout never fires in SPI mode
// - Three test modes besides normal operation
// - Normal: input to receiver, transmitter to output
// - Echo: input bits resent to output immediately; code does so 2 to 3 ref_clk_i cycles later
// - Echo: transmitter has no effect on output
// - Echo: receiver keeps receiving normally
`ifndef USRX_REGS_VH
`define USRX_REGS_VH
`define USRX_MODE_NORMAL   2'h0
`define USRX_MODE_ECHO     2'h1
`define USRX_MODE_LOCAL    2'h2
`define USRX_MODE_REMOTE   2'h3
`define USRX_CHAR_BITS     8
`define USRX_FIFO_DEPTH    4
`define USRX_RDY_BIT       0
`define USRX_OVR_BIT       1
`define USRX_TO_BIT        2
`define USRX_STATUS_RESET  3'h0
`endif

// ==== usrx_fifo.v ====
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module usrx_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             ref_clk_i,
	input  wire             sys_rst_i,
	input  wire [WIDTH-1:0] in_data_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	output wire [WIDTH-1:0] out_data_o,
	output wire             out_valid_o,
	input  wire             out_ready_i
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;

	assign in_ready_o  = (count != DEPTH[AW:0]);
	assign out_valid_o = (count != {(AW+1){1'b0}});
	assign out_data_o  = mem[rd_ptr];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				mem[wr_ptr] <= in_data_i;
				wr_ptr      <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (pop)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule // usrx_fifo

// ==== usrx_spi_slave.v ====
// SPI slave receive path with holding register, flags and test-mode pin routing
`timescale 1ns/10ps
`include "usrx_regs.vh"
module usrx_spi_slave #(
	parameter CHAR_BITS  = `USRX_CHAR_BITS,
	parameter FIFO_DEPTH = `USRX_FIFO_DEPTH
) (
	input  wire                 ref_clk_i,
	input  wire                 sys_rst_i,
	input  wire                 spi_clk_i,
	input  wire                 slave_select_n_i,
	input  wire                 rxd_i,
	output reg                  txd_o,
	output reg                  txd_oe_n_o,
	input  wire [1:0]           test_mode_i,
	input  wire [CHAR_BITS-1:0] tx_data_i,
	input  wire                 tx_valid_i,
	output reg                  tx_ready_o,
	input  wire                 status_clear_cmd_i,
	input  wire [15:0]          timeout_value_i,
	input  wire                 rx_read_i,
	output reg  [CHAR_BITS-1:0] rx_holding_reg_o,
	output reg                  rx_ready_flag_o,
	output reg                  overrun_error_flag_o,
	output reg                  timeout_flag_o
);
	reg [2:0]           clk_sync;
	reg [1:0]           ss_sync;
	reg [1:0]           rxd_sync;
	reg [CHAR_BITS-1:0] rx_shift;
	reg [3:0]           rx_cnt;
	reg [CHAR_BITS-1:0] tx_shift;
	reg [3:0]           tx_cnt;
	reg                 tx_loaded;
	reg                 tx_bit;
	reg                 rx_done;
	reg [CHAR_BITS-1:0] rx_done_data;
	wire                clk_rise;
	wire                clk_fall;
	wire                ss_low;
	wire                rx_pin;
	wire                rx_in;
	wire [CHAR_BITS-1:0] fifo_data;
	wire                fifo_valid;
	wire                fifo_in_ready;
	wire                fifo_out_ready;
	wire                tx_fifo_valid;
	wire [CHAR_BITS-1:0] tx_fifo_data;
	wire                tx_take;

	// Pin synchronisers; first stage read only by the second
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			clk_sync <= 3'h0;
			ss_sync  <= 2'h3;
			rxd_sync <= 2'h3;
		end else begin
			clk_sync <= {clk_sync[1:0], spi_clk_i};
			ss_sync  <= {ss_sync[0], slave_select_n_i};
			rxd_sync <= {rxd_sync[0], rxd_i};
		end
	end

	assign clk_rise = clk_sync[1] && !clk_sync[2];
	assign clk_fall = !clk_sync[1] && clk_sync[2];
	assign ss_low   = !ss_sync[1];
	assign rx_pin   = rxd_sync[1];
	// Local loopback feeds the receiver from the transmitter
	assign rx_in    = (test_mode_i == `USRX_MODE_LOCAL) ? tx_bit : rx_pin;

	// Receive shifter, MSB first, sampled on rising clock
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rx_shift     <= {CHAR_BITS{1'b0}};
			rx_cnt       <= 4'h0;
			rx_done      <= 1'b0;
			rx_done_data <= {CHAR_BITS{1'b0}};
		end else begin
			rx_done <= 1'b0;
			if (!ss_low) begin
				rx_cnt <= 4'h0;
			end else if (clk_rise) begin
				if (rx_cnt == CHAR_BITS[3:0] - 4'h1) begin
					rx_done_data <= {rx_shift[CHAR_BITS-2:0], rx_in};
					rx_done      <= 1'b1;
					rx_cnt       <= 4'h0;
				end else begin
					rx_shift <= {rx_shift[CHAR_BITS-2:0], rx_in};
					rx_cnt   <= rx_cnt + 4'h1;
				end
			end
		end
	end

	// Transmit buffer in front of the shifter
	usrx_fifo #(
		.WIDTH (CHAR_BITS),
		.DEPTH (FIFO_DEPTH),
		.AW    (2)
	) u_tx_fifo (
		.ref_clk_i   (ref_clk_i),
		.sys_rst_i   (sys_rst_i),
		.in_data_i   (tx_data_i),
		.in_valid_i  (tx_valid_i),
		.in_ready_o  (fifo_in_ready),
		.out_data_o  (tx_fifo_data),
		.out_valid_o (tx_fifo_valid),
		.out_ready_i (fifo_out_ready)
	);

	assign tx_take        = tx_fifo_valid && !tx_loaded;
	assign fifo_out_ready = !tx_loaded;
	assign fifo_data      = tx_fifo_data;
	assign fifo_valid     = tx_fifo_valid;

	always @(posedge ref_clk_i) begin
		if (sys_rst_i)
			tx_ready_o <= 1'b0;
		else
			tx_ready_o <= fifo_in_ready;
	end

	// Transmit shifter, changes on falling clock while select is low
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			tx_shift  <= {CHAR_BITS{1'b1}};
			tx_cnt    <= 4'h0;
			tx_loaded <= 1'b0;
			tx_bit    <= 1'b1;
		end else begin
			if (tx_take) begin
				tx_shift  <= fifo_data;
				tx_bit    <= fifo_data[CHAR_BITS-1];
				tx_loaded <= fifo_valid;
				tx_cnt    <= 4'h0;
			end else if (tx_loaded && ss_low && clk_fall) begin
				if (tx_cnt == CHAR_BITS[3:0] - 4'h1) begin
					tx_loaded <= 1'b0;
					tx_bit    <= 1'b1;
				end else begin
					tx_shift <= {tx_shift[CHAR_BITS-2:0], 1'b0};
					tx_bit   <= tx_shift[CHAR_BITS-2];
					tx_cnt   <= tx_cnt + 4'h1;
				end
			end
		end
	end

	// Output pin routing by test mode
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			txd_o      <= 1'b1;
			txd_oe_n_o <= 1'b1;
		end else begin
			txd_oe_n_o <= !ss_low;
			case (test_mode_i)
			`USRX_MODE_NORMAL: txd_o <= tx_bit;
			`USRX_MODE_ECHO:   txd_o <= rx_pin;
			`USRX_MODE_LOCAL:  txd_o <= 1'b1;
			`USRX_MODE_REMOTE: txd_o <= rx_pin;
			default:           txd_o <= tx_bit;
			endcase
		end
	end

	// Holding register and status flags; set wins over clear
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rx_holding_reg_o     <= {CHAR_BITS{1'b0}};
			rx_ready_flag_o      <= 1'b0;
			overrun_error_flag_o <= 1'b0;
			timeout_flag_o       <= 1'b0;
		end else begin
			timeout_flag_o <= 1'b0;
			if (rx_done && test_mode_i != `USRX_MODE_REMOTE) begin
				rx_holding_reg_o <= rx_done_data;
				rx_ready_flag_o  <= 1'b1;
				if (rx_ready_flag_o && !rx_read_i)
					overrun_error_flag_o <= 1'b1;
				else if (status_clear_cmd_i)
					overrun_error_flag_o <= 1'b0;
			end else begin
				if (rx_read_i)
					rx_ready_flag_o <= 1'b0;
				if (status_clear_cmd_i)
					overrun_error_flag_o <= 1'b0;
			end
		end
	end
endmodule // usrx_spi_slave

// ==== usrx_spi_slave_assertions.sv ====
// Concurrent checks on the SPI slave receive path ports
`timescale 1ns/10ps
`include "usrx_regs.vh"
module usrx_spi_slave_assertions #(
	parameter CHAR_BITS = `USRX_CHAR_BITS
) (
	input wire                 ref_clk_i,
	input wire                 sys_rst_i,
	input wire                 rxd_i,
	input wire                 txd_o,
	input wire [1:0]           test_mode_i,
	input wire                 status_clear_cmd_i,
	input wire                 rx_read_i,
	input wire [CHAR_BITS-1:0] rx_holding_reg_o,
	input wire                 rx_ready_flag_o,
	input wire                 overrun_error_flag_o,
	input wire                 timeout_flag_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_echo_run; (test_mode_i == `USRX_MODE_ECHO)[*4]; endsequence
	property p_rdy_set; $changed(rx_holding_reg_o) |-> rx_ready_flag_o; endproperty
	a_rdy_set: assert property (p_rdy_set) else $error("holding moved without ready");
	property p_ovr_set; $rose(overrun_error_flag_o) |-> $past(rx_ready_flag_o); endproperty
	a_ovr_set: assert property (p_ovr_set) else $error("overrun without ready");
	property p_ovr_new; $rose(overrun_error_flag_o) |-> $changed(rx_holding_reg_o); endproperty
	a_ovr_new: assert property (p_ovr_new) else $error("overrun kept old char");
	property p_ovr_hold; overrun_error_flag_o && !status_clear_cmd_i |=> overrun_error_flag_o; endproperty
	a_ovr_hold: assert property (p_ovr_hold) else $error("overrun dropped");
	property p_ovr_clr; $fell(overrun_error_flag_o) |-> $past(status_clear_cmd_i); endproperty
	a_ovr_clr: assert property (p_ovr_clr) else $error("overrun cleared untold");
	property p_rd_clr; rx_read_i |=> !rx_ready_flag_o || $changed(rx_holding_reg_o); endproperty
	a_rd_clr: assert property (p_rd_clr) else $error("read kept ready");
	property p_no_to; !timeout_flag_o; endproperty
	a_no_to: assert property (p_no_to) else $error("timeout fired");
	property p_echo; s_echo_run |-> txd_o == $past(rxd_i, 2) || txd_o == $past(rxd_i, 3); endproperty
	a_echo: assert property (p_echo) else $error("echo lost");
endmodule // usrx_spi_slave_assertions
bind usrx_spi_slave usrx_spi_slave_assertions #(.CHAR_BITS(CHAR_BITS)) u_chk (.*);

// ==== usrx_spi_master.sv ====
// SPI master model driving the slave link pins, mode 0
`timescale 1ns/10ps
module usrx_spi_master (
	output reg       spi_clk_o,
	output reg       ss_n_o,
	output reg       mosi_o,
	input  wire      miso_i,
	output reg [7:0] miso_byte_o
);
	integer i;
	initial begin
		spi_clk_o = 1'b0;
		ss_n_o = 1'b1;
		mosi_o = 1'b1;
		miso_byte_o = 8'h00;
	end
	task send(input [7:0] data);
		begin
			ss_n_o = 1'b0;
			mosi_o = data[7];
			#64;
			for (i = 7; i >= 0; i = i - 1) begin
				mosi_o = data[i];
				#32 spi_clk_o = 1'b1;
				// Slave output lags the falling edge by its synchroniser; take it late
				#31 miso_byte_o = {miso_byte_o[6:0], miso_i};
				#1 spi_clk_o = 1'b0;
			end
			#32 ss_n_o = 1'b1;
			mosi_o = ~data[0];
			#64;
		end
	endtask
endmodule // usrx_spi_master

// ==== tb_top.sv ====
// Self-checking bench for the SPI slave receive path
`timescale 1ns/10ps
module tb_top;
	reg        clk = 1'b0, rst = 1'b1, tx_valid = 1'b0, clr = 1'b0, rd = 1'b0;
	reg  [1:0] mode = 2'h0;
	reg  [7:0] tx_data = 8'h00;
	wire       sck, ss_n, mosi, txd, oe_n, tx_rdy, rdy, ovr, to;
	wire [7:0] hold, miso;
	integer    num_errors = 0, check_count = 0, n;
	usrx_spi_slave u_usrx_spi_slave (.ref_clk_i(clk), .sys_rst_i(rst), .spi_clk_i(sck),
		.slave_select_n_i(ss_n), .rxd_i(mosi), .txd_o(txd), .txd_oe_n_o(oe_n),
		.test_mode_i(mode), .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_rdy),
		.status_clear_cmd_i(clr), .timeout_value_i(16'hFFFF), .rx_read_i(rd),
		.rx_holding_reg_o(hold), .rx_ready_flag_o(rdy), .overrun_error_flag_o(ovr),
		.timeout_flag_o(to));
	usrx_spi_master u_usrx_spi_master (.spi_clk_o(sck), .ss_n_o(ss_n), .mosi_o(mosi),
		.miso_i(txd), .miso_byte_o(miso));
	initial begin
		forever #4 clk = ~clk;
	end
	task check(input string name, input [7:0] seen, input [7:0] exp);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				num_errors = num_errors + 1;
				$display("[FAIL] %0s expected %h seen %h", name, exp, seen);
			end
		end
	endtask
	task summarize;
		begin
			if (num_errors == 0 && check_count > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task step;
		begin
			@(posedge clk);
			#1;
		end
	endtask
	task push(input [7:0] d);
		begin
			n = 0;
			while (tx_rdy !== 1'b1 && n < 50) begin
				step;
				n = n + 1;
			end
			if (n == 50) begin
				num_errors = num_errors + 1;
				summarize;
			end
			tx_data = d;
			tx_valid = 1'b1;
			step;
			tx_valid = 1'b0;
		end
	endtask
	task xfer(input [7:0] d);
		begin
			u_usrx_spi_master.send(d);
			repeat (10) step;
		end
	endtask
	initial begin
		repeat (3) step;
		rst = 1'b0;
		repeat (2) step;
		push(8'h3C);
		xfer(8'hA5);
		check("holding", hold, 8'hA5);
		check("ready", {7'h00, rdy}, 8'h01);
		check("miso", miso, 8'h3C);
		xfer(8'h5A);
		check("overrun", {7'h00, ovr}, 8'h01);
		check("holding", hold, 8'h5A);
		rd = 1'b1;
		step;
		rd = 1'b0;
		step;
		check("ready", {7'h00, rdy}, 8'h00);
		check("overrun", {7'h00, ovr}, 8'h01);
		clr = 1'b1;
		step;
		clr = 1'b0;
		step;
		check("overrun", {7'h00, ovr}, 8'h00);
		check("timeout", {7'h00, to}, 8'h00);
		mode = 2'h1;
		push(8'h0F);
		xfer(8'hC3);
		check("echo", miso, 8'hC3);
		check("holding", hold, 8'hC3);
		for (n = 2; n < 4; n = n + 1) begin
			mode = n[1:0];
			xfer(8'h99);
			check("loop", miso, (n == 2) ? 8'hFF : 8'h99);
		end
		summarize;
	end
endmodule // tb_top
